// file: hw/drs_sequencer.v
// Operation
// - Scheme selector 0..4, reset value 4
// - Any terminal routes to any sequencing slot
// - Codes: latch, latch-dir, wire-proof, PLC, wire-proof PLC
// - Mapping required except scheme 4 defaults
// - Scheme 0: permit, run, jog, direction
// - Scheme 0: run pulse latches, permit low stops
// - Scheme 0: enabled keypad replaces terminal function
// - Jog accepted only from ready state
// - Schemes 0,1: run beats jog
// - Scheme 1: run/jog per direction, permit needed
// - Scheme 1: run pulse latches direction, permit stops
// - Scheme 1: opposite run pulse reverses
// - Scheme 1: keypad run/dir unless terminal held
// - Scheme 1: keypad halt unless terminals force run
// - Scheme 2: held levels fwd, jog, rev
// - Scheme 2: runs with permit and one direction
// - Scheme 2: both directions stop after 60 ms
// - Scheme 2: keypad buttons ignored
// - Scheme 3: level run, jog, direction; no keypad
// - Scheme 4: level fwd/rev, both stop, delay; the code delays only in open loop
//
// Implementation choices: the APB interface to the registers and the register offsets.
`include "drs_map.vh"
`timescale 1ns/10ps
`default_nettype none
module drs_sequencer #(
    parameter NUM_TERM = 8,
    parameter BOTH_DELAY_CYC = `DRS_BOTH_DELAY_US * `DRS_CLK_MHZ,
    parameter CNT_W = 24
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    input wire [NUM_TERM-1:0] i_term,
    input wire i_kp_run,
    input wire i_kp_halt,
    input wire i_kp_dir,
    output reg o_run,
    output reg o_dir,
    output reg o_jog,
    output reg o_stop,
    output reg [1:0] o_state
);
    localparam SW = NUM_TERM + 3;
    localparam [CNT_W-1:0] BOTH_CYC = BOTH_DELAY_CYC;

    // ==========================================
    // Registers
    reg [2:0] scheme;
    reg [3:0] ctrl;
    reg [14:0] map;
    reg [1:0] state;
    reg [1:0] next_state;
    reg dir;
    reg next_dir;
    reg [CNT_W-1:0] both_cnt;

    wire access = i_psel & i_penable;
    wire hit_scheme = (i_paddr == `DRS_OFS_SCHEME);
    wire hit_ctrl = (i_paddr == `DRS_OFS_CTRL);
    wire hit_map = (i_paddr == `DRS_OFS_MAP);
    wire hit_status = (i_paddr == `DRS_OFS_STATUS);
    wire hit_any = hit_scheme | hit_ctrl | hit_map | hit_status;

    assign o_pready = 1'b1;
    // Unmapped addresses answer with an error and zero data
    assign o_pslverr = i_psel & ~hit_any;
    assign o_prdata = hit_scheme ? {29'h0, scheme} :
                      hit_ctrl ? {28'h0, ctrl} :
                      hit_map ? {17'h0, map} :
                      hit_status ? {27'h0, o_stop, o_jog, dir, state} :
                      32'h0;

    always @(posedge i_clk) begin
        if (i_rst) begin
            scheme <= `DRS_SCHEME_RST;
            ctrl <= `DRS_CTRL_RST;
            map <= `DRS_MAP_RST;
        end else if (access & i_pwrite) begin
            // Out-of-range scheme codes are dropped, not clamped
            if (hit_scheme && i_pwdata[2:0] <= `DRS_SCHEME_MAX) begin
                scheme <= i_pwdata[2:0];
            end
            if (hit_ctrl) begin
                ctrl <= i_pwdata[3:0];
            end
            if (hit_map) begin
                map <= i_pwdata[14:0];
            end
        end
    end

    // ==========================================
    // Input synchronisers
    wire [SW-1:0] raw = {i_kp_dir, i_kp_halt, i_kp_run, i_term};
    reg [SW-1:0] sy1;
    reg [SW-1:0] sy2;
    reg [SW-1:0] sy3;
    genvar g;
    generate
        for (g = 0; g < SW; g = g + 1) begin : g_sync
            always @(posedge i_clk) begin
                if (i_rst) begin
                    sy1[g] <= 1'b0;
                    sy2[g] <= 1'b0;
                    sy3[g] <= 1'b0;
                end else begin
                    sy1[g] <= raw[g];
                    sy2[g] <= sy1[g];
                    sy3[g] <= sy2[g];
                end
            end
        end
    endgenerate

    // ==========================================
    // Terminal routing
    wire use_default = (scheme == `DRS_SCH_WP_PLC);
    wire [14:0] map_eff = use_default ? `DRS_MAP_DEFAULT : map;
    wire [4:0] lvl;
    wire [4:0] prv;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_route
            wire [2:0] sel = map_eff[g*3 +: 3];
            assign lvl[g] = sy2[sel];
            assign prv[g] = sy3[sel];
        end
    endgenerate
    wire [4:0] rise = lvl & ~prv;

    wire permit = lvl[`DRS_SLOT_PERMIT];
    wire in0 = lvl[`DRS_SLOT_IN0];
    wire in1 = lvl[`DRS_SLOT_IN1];
    wire in2 = lvl[`DRS_SLOT_IN2];
    wire in3 = lvl[`DRS_SLOT_IN3];
    wire kp_run = sy2[NUM_TERM] & ~sy3[NUM_TERM];
    wire kp_halt = sy2[NUM_TERM+1] & ~sy3[NUM_TERM+1];
    wire kp_dir = sy2[NUM_TERM+2] & ~sy3[NUM_TERM+2];
    wire run_en = ctrl[`DRS_CTRL_RUN_EN];
    wire halt_en = ctrl[`DRS_CTRL_HALT_EN];
    wire dir_en = ctrl[`DRS_CTRL_DIR_EN];
    wire open_loop = ctrl[`DRS_CTRL_OPEN_LOOP];

    // ==========================================
    // Both-direction stop delay
    wire wp = (scheme == `DRS_SCH_WIRE_PROOF) |
              (scheme == `DRS_SCH_WP_PLC);
    wire both = wp & in0 & in2;
    // Closed-loop scheme 4 stops at once on both directions
    wire delay_on = (scheme == `DRS_SCH_WIRE_PROOF) | open_loop;
    wire both_done = (both_cnt >= BOTH_CYC);
    always @(posedge i_clk) begin
        if (i_rst) begin
            both_cnt <= {CNT_W{1'b0}};
        end else if (~both) begin
            both_cnt <= {CNT_W{1'b0}};
        end else if (~both_done) begin
            both_cnt <= both_cnt + 1'b1;
        end
    end
    wire both_hold = both & delay_on & ~both_done;

    // ==========================================
    // Sequencing decisions
    reg run_ev;
    reg stop_c;
    reg jog_c;
    reg jog_dir;
    reg run_c;
    reg dir_c;
    reg latched;
    reg held;
    always @* begin
        run_ev = 1'b0;
        stop_c = 1'b0;
        jog_c = 1'b0;
        jog_dir = dir;
        run_c = 1'b0;
        dir_c = dir;
        latched = 1'b0;
        held = in0 | in2;
        next_dir = dir;
        case (scheme)
            `DRS_SCH_LATCH: begin
                latched = 1'b1;
                run_ev = run_en ? kp_run : rise[`DRS_SLOT_IN0];
                stop_c = halt_en ? kp_halt : ~permit;
                jog_c = in1 & (halt_en | permit);
                if (dir_en) begin
                    next_dir = dir ^ kp_dir;
                end else begin
                    next_dir = in2;
                end
                jog_dir = next_dir;
            end
            `DRS_SCH_LATCH_DIR: begin
                latched = 1'b1;
                run_ev = rise[`DRS_SLOT_IN0] | rise[`DRS_SLOT_IN2] |
                         (run_en & kp_run & ~held);
                stop_c = ~permit | (halt_en & kp_halt & ~held);
                jog_c = (in1 | in3) & permit;
                jog_dir = in3 & ~in1;
                if (rise[`DRS_SLOT_IN2]) begin
                    next_dir = 1'b1;
                end else if (rise[`DRS_SLOT_IN0]) begin
                    next_dir = 1'b0;
                end else if (dir_en & kp_dir & ~held) begin
                    next_dir = ~dir;
                end
            end
            `DRS_SCH_WIRE_PROOF, `DRS_SCH_WP_PLC: begin
                // Keypad inputs are not consulted here
                run_c = permit & (in0 ^ in2);
                jog_c = run_c & in1;
                dir_c = in2;
            end
            `DRS_SCH_PLC: begin
                run_c = in0;
                jog_c = in0 & in1;
                dir_c = in2;
            end
            default: begin
                run_c = 1'b0;
            end
        endcase
    end

    // ==========================================
    // State machine
    always @* begin
        next_state = state;
        if (latched) begin
            case (state)
                `DRS_ST_READY: begin
                    if (run_ev & ~stop_c) begin
                        next_state = `DRS_ST_RUN;
                    end else if (jog_c & ~stop_c) begin
                        next_state = `DRS_ST_JOG;
                    end
                end
                `DRS_ST_RUN: begin
                    if (stop_c) begin
                        next_state = `DRS_ST_READY;
                    end
                end
                `DRS_ST_JOG: begin
                    if (run_ev & ~stop_c) begin
                        next_state = `DRS_ST_RUN;
                    end else if (~jog_c | stop_c) begin
                        next_state = `DRS_ST_READY;
                    end
                end
                default: begin
                    next_state = `DRS_ST_READY;
                end
            endcase
        end else begin
            case (state)
                `DRS_ST_READY: begin
                    // Jog seen with run at once; run first means run
                    if (jog_c) begin
                        next_state = `DRS_ST_JOG;
                    end else if (run_c) begin
                        next_state = `DRS_ST_RUN;
                    end
                end
                `DRS_ST_RUN: begin
                    if (~run_c & ~both_hold) begin
                        next_state = `DRS_ST_READY;
                    end
                end
                `DRS_ST_JOG: begin
                    if (~jog_c) begin
                        next_state = `DRS_ST_READY;
                    end
                end
                default: begin
                    next_state = `DRS_ST_READY;
                end
            endcase
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            state <= `DRS_ST_READY;
            dir <= 1'b0;
        end else begin
            state <= next_state;
            if (latched) begin
                dir <= next_dir;
            end else if (run_c | jog_c) begin
                dir <= dir_c;
            end
        end
    end

    // ==========================================
    // Outputs to the speed controller
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_run <= 1'b0;
            o_dir <= 1'b0;
            o_jog <= 1'b0;
            o_stop <= 1'b0;
            o_state <= `DRS_ST_READY;
        end else begin
            o_run <= (next_state == `DRS_ST_RUN);
            o_jog <= (next_state == `DRS_ST_JOG);
            o_dir <= (next_state == `DRS_ST_JOG) ? jog_dir : dir;
            o_stop <= (state != `DRS_ST_READY) &
                      (next_state == `DRS_ST_READY);
            o_state <= next_state;
        end
    end
endmodule // drs_sequencer
`default_nettype wire

// file: inc/drs_map.vh
`ifndef DRS_MAP_VH
`define DRS_MAP_VH
// ==========================================
// Register offsets
`define DRS_OFS_SCHEME 12'h000
`define DRS_OFS_CTRL 12'h004
`define DRS_OFS_MAP 12'h008
`define DRS_OFS_STATUS 12'h00c
// ==========================================
// Reset values and top scheme code
`define DRS_SCHEME_RST 3'h4
`define DRS_SCHEME_MAX 3'h4
`define DRS_CTRL_RST 4'h0
`define DRS_MAP_RST 15'h0000
// ==========================================
// Control fields
`define DRS_CTRL_RUN_EN 0
`define DRS_CTRL_HALT_EN 1
`define DRS_CTRL_DIR_EN 2
`define DRS_CTRL_OPEN_LOOP 3
// ==========================================
// Sequencing input slots
`define DRS_SLOT_PERMIT 0
`define DRS_SLOT_IN0 1
`define DRS_SLOT_IN1 2
`define DRS_SLOT_IN2 3
`define DRS_SLOT_IN3 4
`define DRS_MAP_FIELD_W 3
// Default terminals of the wire-proof PLC scheme, slot k on terminal k
`define DRS_MAP_DEFAULT 15'h4688
// ==========================================
// Schemes
`define DRS_SCH_LATCH 3'h0
`define DRS_SCH_LATCH_DIR 3'h1
`define DRS_SCH_WIRE_PROOF 3'h2
`define DRS_SCH_PLC 3'h3
`define DRS_SCH_WP_PLC 3'h4
// ==========================================
// Sequencer states
`define DRS_ST_READY 2'h0
`define DRS_ST_RUN 2'h1
`define DRS_ST_JOG 2'h2
// ==========================================
// Timing
`define DRS_CLK_MHZ 100
`define DRS_BOTH_DELAY_US 60000
`endif

// file: tb/drs_props.sv
`include "drs_map.vh"
`timescale 1ns/10ps
`default_nettype none
module drs_props (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_run,
    input wire logic o_jog,
    input wire logic o_stop,
    input wire logic [1:0] o_state
);
    logic [2:0] sch;
    // ====
    // Scheme shadow; codes above the top one are dropped
    always @(posedge i_clk) begin
        if (i_rst)
            sch <= `DRS_SCHEME_RST;
        else if (i_psel && i_penable && i_pwrite &&
                 i_paddr == `DRS_OFS_SCHEME &&
                 i_pwdata[2:0] <= `DRS_SCHEME_MAX)
            sch <= i_pwdata[2:0];
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ====
    // Properties
    property p_stop_one; o_stop |=> !o_stop; endproperty
    a_stop_one: assert property (p_stop_one) else $error("stop pulse long");
    property p_stop_why; o_stop |-> o_state == 2'h0 && $past(o_state) != 2'h0;
    endproperty
    a_stop_why: assert property (p_stop_why) else $error("stray stop");
    property p_jog_rdy; $rose(o_jog) |-> $past(o_state) == 2'h0; endproperty
    a_jog_rdy: assert property (p_jog_rdy) else $error("jog not from ready");
    property p_run_st; o_run |-> o_state == 2'h1; endproperty
    a_run_st: assert property (p_run_st) else $error("run flag state");
    property p_run_jog; !(o_run && o_jog); endproperty
    a_run_jog: assert property (p_run_jog) else $error("run with jog");
    property p_err; i_psel && i_paddr > `DRS_OFS_STATUS |->
        o_pslverr && o_prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("unmapped answer");
    property p_sch; i_psel && i_paddr == `DRS_OFS_SCHEME |->
        !o_pslverr && o_prdata == {29'h0, sch}; endproperty
    a_sch: assert property (p_sch) else $error("scheme readback");
    property p_legal; o_state != 2'h3; endproperty
    a_legal: assert property (p_legal) else $error("bad state");
    c_stop: cover property (o_stop);
    c_jog: cover property ($rose(o_jog));
    c_err: cover property (o_pslverr);
endmodule // drs_props
bind drs_sequencer drs_props u_props (.i_clk, .i_rst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .o_run, .o_jog, .o_stop, .o_state);
`default_nettype wire

// file: tb/drs_contacts.sv
`timescale 1ns/10ps
`default_nettype none
module drs_contacts (
    input wire logic i_clk,
    input wire logic i_jog_first,
    input wire logic [7:0] i_want,
    output var logic [7:0] o_term = 8'h00
);
    // ====
    // Contacts move once per scan; jog may be made to close a scan early
    always @(posedge i_clk) begin
        if (i_jog_first && i_want[2] && !o_term[2])
            o_term <= o_term | 8'h04;
        else
            o_term <= i_want;
    end
endmodule // drs_contacts
`default_nettype wire

// file: tb/tb_top.sv
`include "drs_map.vh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, s, e) begin num_checks++; if ((s) !== (e)) begin \
    error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_top;
    logic i_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic i_kp_run = 0, i_kp_halt = 0, i_kp_dir = 0, jog_first = 0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, rnd;
    logic [7:0] want = 8'h00;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    wire logic [31:0] o_prdata;
    wire logic o_pready, o_pslverr, o_run, o_dir, o_jog, o_stop;
    wire logic [1:0] o_state;
    wire logic [7:0] i_term;
    integer seed = 9, error_cnt = 0, num_checks = 0, i;
    drs_sequencer #(.BOTH_DELAY_CYC(20)) dut_u (.i_clk, .i_rst, .i_psel,
        .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
        .o_pslverr, .i_term, .i_kp_run, .i_kp_halt, .i_kp_dir, .o_run,
        .o_dir, .o_jog, .o_stop, .o_state);
    drs_contacts u_plc (.i_clk, .i_jog_first(jog_first), .i_want(want),
        .o_term(i_term));
    initial forever #5 i_clk = ~i_clk;
    // ====
    // Bus and contact tasks
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [32:0] x);
        if (!w)
            exp_q.push_back(x);
        i_psel <= 1'h1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'h1;
        @(posedge i_clk);
        while (o_pready !== 1'h1) @(posedge i_clk);
        i_psel <= 1'h0;
        i_penable <= 1'h0;
        @(posedge i_clk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d, 33'h0);
    endtask
    task rd(input logic [11:0] a, input logic [32:0] x);
        apb(1'h0, a, 32'h0, x);
    endtask
    task chk(input logic [7:0] t, input logic [4:0] s);
        want <= t;
        repeat (8) @(posedge i_clk);
        rd(`DRS_OFS_STATUS, {28'h0, s});
        `CHK("run", o_run, s[1:0] == 2'h1)
        `CHK("state", o_state, s[1:0])
        if (s[1:0] != 2'h2)
            `CHK("dir", o_dir, s[2])
    endtask
    task kp(input integer k);
        {i_kp_dir, i_kp_halt, i_kp_run} <= 3'h1 << k;
        repeat (4) @(posedge i_clk);
        {i_kp_dir, i_kp_halt, i_kp_run} <= 3'h0;
        @(posedge i_clk);
    endtask
    // Both directions held: still running at first, stopped once delayed
    task both;
        chk(8'h03, 5'h01);
        want <= 8'h0b;
        repeat (4) @(posedge i_clk);
        rd(`DRS_OFS_STATUS, 33'h1);
        repeat (30) @(posedge i_clk);
        rd(`DRS_OFS_STATUS, 33'h0);
        chk(8'h00, 5'h00);
    endtask
    task results;
        if (error_cnt == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ====
    // Result checker
    always @(posedge i_clk) begin
        if (i_psel && i_penable && o_pready && !i_pwrite) begin
            e = exp_q.pop_front();
            `CHK("read", {o_pslverr, o_prdata}, e)
        end
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        results;
    end
    // ====
    // Main sequence
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'h0;
        @(posedge i_clk);
        rd(`DRS_OFS_SCHEME, {30'h0, `DRS_SCHEME_RST});
        rd(`DRS_OFS_MAP, 33'h0);
        rd(12'h010, {1'h1, 32'h0});
        wr(`DRS_OFS_SCHEME, 32'h5);
        rd(`DRS_OFS_SCHEME, 33'h4);
        for (i = 0; i < 5; i++) begin
            wr(`DRS_OFS_SCHEME, i);
            rd(`DRS_OFS_SCHEME, i);
        end
        rnd = $random(seed);
        wr(`DRS_OFS_CTRL, rnd);
        rd(`DRS_OFS_CTRL, {29'h0, rnd[3:0]});
        wr(`DRS_OFS_CTRL, 32'h0);
        wr(`DRS_OFS_MAP, 32'h4688);
        rd(`DRS_OFS_MAP, 33'h4688);
        wr(`DRS_OFS_SCHEME, 32'h0);
        chk(8'h03, 5'h01);
        chk(8'h09, 5'h05);
        chk(8'h0d, 5'h05);
        chk(8'h01, 5'h01);
        chk(8'h00, 5'h00);
        chk(8'h07, 5'h01);
        chk(8'h00, 5'h00);
        chk(8'h05, 5'h0a);
        chk(8'h01, 5'h00);
        wr(`DRS_OFS_CTRL, 32'h1);
        chk(8'h03, 5'h00);
        kp(0);
        chk(8'h01, 5'h01);
        chk(8'h00, 5'h00);
        wr(`DRS_OFS_SCHEME, 32'h1);
        wr(`DRS_OFS_CTRL, 32'h2);
        chk(8'h03, 5'h01);
        chk(8'h09, 5'h05);
        chk(8'h03, 5'h01);
        kp(1);
        chk(8'h01, 5'h01);
        kp(1);
        chk(8'h01, 5'h00);
        chk(8'h05, 5'h0a);
        chk(8'h01, 5'h00);
        chk(8'h11, 5'h0a);
        `CHK("jog dir", o_dir, 1'h1)
        wr(`DRS_OFS_CTRL, 32'h4);
        chk(8'h03, 5'h01);
        kp(2);
        chk(8'h01, 5'h01);
        kp(2);
        chk(8'h01, 5'h05);
        kp(2);
        chk(8'h01, 5'h01);
        chk(8'h00, 5'h00);
        wr(`DRS_OFS_SCHEME, 32'h2);
        wr(`DRS_OFS_CTRL, 32'h7);
        chk(8'h03, 5'h01);
        chk(8'h01, 5'h00);
        kp(0);
        chk(8'h01, 5'h00);
        both;
        jog_first <= 1'h1;
        chk(8'h07, 5'h0a);
        chk(8'h00, 5'h00);
        jog_first <= 1'h0;
        wr(`DRS_OFS_SCHEME, 32'h3);
        chk(8'h02, 5'h01);
        chk(8'h00, 5'h00);
        wr(`DRS_OFS_SCHEME, 32'h4);
        wr(`DRS_OFS_CTRL, 32'h8);
        chk(8'h09, 5'h05);
        chk(8'h03, 5'h01);
        chk(8'h01, 5'h00);
        both;
        results;
    end
endmodule // tb_top
`default_nettype wire
